/* or_pop_decode_pkg.sv */
/*
  Constants for the logical OR and pop decoder: opcode patterns, field
  positions, operand codes, instruction lengths and cycle counts.
  Assumes a byte-wide opcode stream presented two bytes at a time.
*/
package or_pop_decode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction classes reported to the sequencer
  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_OR_IMM_G = 4'h1,
    CLS_OR_IMM_S = 4'h2,
    CLS_OR_RM_G = 4'h3,
    CLS_OR_RM_S = 4'h4,
    CLS_POP_G = 4'h5,
    CLS_POP_B_S = 4'h6,
    CLS_POP_W_S = 4'h7,
    CLS_POP_CTRL = 4'h8,
    CLS_POP_MULTI = 4'h9
  } insn_class_t;

  // Control register targets of the control register pop
  typedef enum logic [2:0] {
    CTRL_NONE = 3'h0,
    CTRL_VECTOR_TABLE_BASE_LOW = 3'h1,
    CTRL_VECTOR_TABLE_BASE_HIGH = 3'h2,
    CTRL_FLAG_REGISTER = 3'h3,
    CTRL_INTERRUPT_STACK_POINTER = 3'h4,
    CTRL_USER_STACK_POINTER = 3'h5,
    CTRL_STATIC_BASE_REGISTER = 3'h6,
    CTRL_FRAME_BASE_REGISTER = 3'h7
  } ctrl_reg_t;

  ////////////////////////////////////////////////////////////////////////////
  // First-byte patterns (upper seven bits for general forms, upper five for short OR, full byte for control and multi pop)
  localparam logic [6:0] OP0_OR_IMM_G = 7'h3b;
  localparam logic [6:0] OP0_OR_RM_G = 7'h4c;
  localparam logic [6:0] OP0_POP_G = 7'h3a;
  localparam logic [4:0] OP0_OR_IMM_S = 5'h13;
  localparam logic [4:0] OP0_OR_RM_S = 5'h03;
  localparam logic [7:0] OP0_POP_CTRL = 8'heb;
  localparam logic [7:0] OP0_POP_MULTI = 8'hed;
  // Short pops: upper nibble with bit 3 as target, low three bits fixed
  localparam logic [3:0] OP0_POP_B_S = 4'h9;
  localparam logic [3:0] OP0_POP_W_S = 4'hd;
  localparam logic [2:0] OP0_POP_S_TAIL = 3'h2;

  // Second-byte patterns (upper nibble for general forms)
  localparam logic [3:0] OP1_OR_IMM_G = 4'h3;
  localparam logic [3:0] OP1_POP_G = 4'hd;
  localparam logic [3:0] OP1_POP_CTRL_TAIL = 4'h3;

  // Field positions
  localparam int SIZE_BIT = 0;
  localparam int SHORT_TGT_BIT = 2;
  localparam int POP_S_TGT_BIT = 3;
  localparam int CTRL_LSB = 4;

  // Short-form OR immediate target codes
  localparam logic [2:0] SIMM_FIRST_GPR_HIGH = 3'h3;
  localparam logic [2:0] SIMM_FIRST_GPR_LOW = 3'h4;
  localparam logic [2:0] SIMM_ABS16 = 3'h7;

  // Short-form OR source modes
  localparam logic [1:0] SSRC_OTHER_BYTE = 2'h0;
  localparam logic [1:0] SSRC_DSP8_STATIC = 2'h1;
  localparam logic [1:0] SSRC_DSP8_FRAME = 2'h2;
  localparam logic [1:0] SSRC_ABS16 = 2'h3;

  // Byte select of the first general register
  localparam logic BYTE_SEL_LOW = 1'b0;
  localparam logic BYTE_SEL_HIGH = 1'b1;

  // Highest general operand code that names a register (data or address)
  localparam logic [3:0] GEN_LAST_REG = 4'h5;

  // Multi-pop mask bit positions, most significant first
  localparam int MASK_FRAME_BASE = 7;
  localparam int MASK_STATIC_BASE = 6;
  localparam int MASK_ADDR_REG_ONE = 5;
  localparam int MASK_ADDR_REG_ZERO = 4;
  localparam int MASK_DATA_R3 = 3;
  localparam int MASK_DATA_R0 = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Lengths (bytes) and cycle counts
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_WORD_IMM_EXTRA = 3'h1;
  localparam logic [4:0] CYC_ONE = 5'h01;
  localparam logic [4:0] CYC_TWO = 5'h02;
  localparam logic [4:0] CYC_THREE = 5'h03;
  localparam logic [4:0] CYC_FOUR = 5'h04;
  localparam logic [3:0] MULTI_MIN_COUNT = 4'h2;

  // Stack step sizes
  localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
  localparam logic [15:0] SP_STEP_WORD = 16'h0002;

endpackage

/* or_pop_decoder.sv */
/*
  Decoder for the logical OR and pop instruction group: classifies the
  first two opcode bytes, reports length, cycle count, operand fields and
  the stack address and updated stack pointer of pops.
  Assumes the fetch unit presents bytes synchronous to core_clk_i and
  holds the active stack pointer valid with the request.
*/
// Operation
// - Word general OR immediate is one byte longer than its byte form.
// - Short byte OR immediate: register 2/1, displaced 3/3, absolute 4/3.
// - Short OR target bit: 0 low byte, 1 high byte of first register.
// - Short OR source: 00 other byte, 01 static, 10 frame, 11 absolute.
// - Short OR source: register 1/2, displaced 2/3, absolute 3/3.
// - General pop: register 2/3, memory 4 cycles, plus displacement bytes.
// - Control pop target codes 001..111 map to registers; 000 is rejected.
// - Multi pop mask, MSB first: FB, SB, A1, A0, then data registers.
// - Multi pop is 2 bytes; two or more restores take 2 cycles each.
module or_pop_decoder
  import or_pop_decode_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic dec_valid_i,
  input wire logic [7:0] op_byte0_i,
  input wire logic [7:0] op_byte1_i,
  input wire logic [15:0] stack_ptr_i,
  output logic dec_done_o,
  output insn_class_t insn_class_o,
  output logic illegal_o,
  output logic [2:0] insn_len_o,
  output logic [4:0] insn_cycles_o,
  output logic size_word_o,
  output logic [3:0] src_code_o,
  output logic [3:0] dest_code_o,
  output logic byte_sel_o,
  output logic [1:0] short_src_o,
  output ctrl_reg_t ctrl_sel_o,
  output logic [7:0] restore_mask_o,
  output logic [15:0] pop_addr_o,
  output logic [15:0] new_sp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers for general operand codes

  function automatic logic [2:0] ext_bytes(input logic [3:0] code);
    // Codes 10xx carry an 8-bit displacement, 11xx a 16-bit one
    ext_bytes = code[3] ? (code[2] ? 3'h2 : 3'h1) : 3'h0;
  endfunction

  function automatic logic is_reg(input logic [3:0] code);
    is_reg = (code <= GEN_LAST_REG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registered decode results

  logic done_ff, nxt_done;
  insn_class_t class_ff, nxt_class;
  logic illegal_ff, nxt_illegal;
  logic [2:0] len_ff, nxt_len;
  logic [4:0] cyc_ff, nxt_cyc;
  logic word_ff, nxt_word;
  logic [3:0] src_ff, nxt_src;
  logic [3:0] dest_ff, nxt_dest;
  logic bsel_ff, nxt_bsel;
  logic [1:0] ssrc_ff, nxt_ssrc;
  ctrl_reg_t ctrl_ff, nxt_ctrl;
  logic [7:0] mask_ff, nxt_mask;
  logic [15:0] paddr_ff, nxt_paddr;
  logic [15:0] sp_ff, nxt_sp;

  logic [3:0] restore_cnt;
  logic [15:0] sp_step;
  logic is_pop;

  always_comb begin
    restore_cnt = 4'h0;
    for (int i = MASK_DATA_R0; i <= MASK_FRAME_BASE; i++) begin
      restore_cnt = restore_cnt + {3'h0, op_byte1_i[i]};
    end
  end

  always_comb begin
    nxt_done = dec_valid_i;
    nxt_class = CLS_NONE;
    nxt_illegal = 1'b0;
    nxt_len = LEN_ONE;
    nxt_cyc = CYC_ONE;
    nxt_word = op_byte0_i[SIZE_BIT];
    nxt_src = 4'h0;
    nxt_dest = 4'h0;
    nxt_bsel = BYTE_SEL_LOW;
    nxt_ssrc = SSRC_OTHER_BYTE;
    nxt_ctrl = CTRL_NONE;
    nxt_mask = 8'h00;
    sp_step = 16'h0000;
    is_pop = 1'b0;
    if (!dec_valid_i) begin
      // Length and cycles read zero outside an answer so the sequencer never acts on stale counts
      nxt_word = 1'b0;
      nxt_len = 3'h0;
      nxt_cyc = 5'h00;
    end else if (op_byte0_i[7:1] == OP0_OR_IMM_G && op_byte1_i[7:4] == OP1_OR_IMM_G) begin
      nxt_class = CLS_OR_IMM_G;
      nxt_dest = op_byte1_i[3:0];
      nxt_len = LEN_THREE + ext_bytes(op_byte1_i[3:0])
              + (nxt_word ? LEN_WORD_IMM_EXTRA : 3'h0);
      nxt_cyc = is_reg(op_byte1_i[3:0]) ? CYC_TWO : CYC_FOUR;
    end else if (op_byte0_i[7:1] == OP0_OR_RM_G) begin
      nxt_class = CLS_OR_RM_G;
      nxt_src = op_byte1_i[7:4];
      nxt_dest = op_byte1_i[3:0];
      nxt_len = LEN_TWO + ext_bytes(op_byte1_i[7:4]) + ext_bytes(op_byte1_i[3:0]);
      // Each memory operand adds one cycle to the register-register time
      nxt_cyc = CYC_TWO + {4'h0, ~is_reg(op_byte1_i[7:4])} + {4'h0, ~is_reg(op_byte1_i[3:0])};
    end else if (op_byte0_i[7:1] == OP0_POP_G && op_byte1_i[7:4] == OP1_POP_G) begin
      nxt_class = CLS_POP_G;
      nxt_dest = op_byte1_i[3:0];
      nxt_len = LEN_TWO + ext_bytes(op_byte1_i[3:0]);
      nxt_cyc = is_reg(op_byte1_i[3:0]) ? CYC_THREE : CYC_FOUR;
      is_pop = 1'b1;
      sp_step = nxt_word ? SP_STEP_WORD : SP_STEP_BYTE;
    end else if (op_byte0_i[7:3] == OP0_OR_IMM_S && op_byte0_i[2:0] >= SIMM_FIRST_GPR_HIGH) begin
      nxt_class = CLS_OR_IMM_S;
      nxt_word = 1'b0;
      nxt_dest = {1'b0, op_byte0_i[2:0]};
      nxt_bsel = (op_byte0_i[2:0] == SIMM_FIRST_GPR_HIGH) ? BYTE_SEL_HIGH : BYTE_SEL_LOW;
      if (op_byte0_i[2:0] <= SIMM_FIRST_GPR_LOW) begin
        nxt_len = LEN_TWO;
        nxt_cyc = CYC_ONE;
      end else begin
        nxt_len = (op_byte0_i[2:0] == SIMM_ABS16) ? 3'h4 : LEN_THREE;
        nxt_cyc = CYC_THREE;
      end
    end else if (op_byte0_i[7:3] == OP0_OR_RM_S) begin
      nxt_class = CLS_OR_RM_S;
      nxt_word = 1'b0;
      nxt_bsel = op_byte0_i[SHORT_TGT_BIT] ? BYTE_SEL_HIGH : BYTE_SEL_LOW;
      nxt_ssrc = op_byte0_i[1:0];
      case (op_byte0_i[1:0])
        SSRC_OTHER_BYTE: begin
          nxt_len = LEN_ONE;
          nxt_cyc = CYC_TWO;
        end
        SSRC_DSP8_STATIC, SSRC_DSP8_FRAME: begin
          nxt_len = LEN_TWO;
          nxt_cyc = CYC_THREE;
        end
        default: begin
          nxt_len = LEN_THREE;
          nxt_cyc = CYC_THREE;
        end
      endcase
    end else if (op_byte0_i[2:0] == OP0_POP_S_TAIL
                 && (op_byte0_i[7:4] == OP0_POP_B_S || op_byte0_i[7:4] == OP0_POP_W_S)) begin
      nxt_word = (op_byte0_i[7:4] == OP0_POP_W_S);
      nxt_class = nxt_word ? CLS_POP_W_S : CLS_POP_B_S;
      nxt_bsel = op_byte0_i[POP_S_TGT_BIT];
      nxt_len = LEN_ONE;
      nxt_cyc = CYC_THREE;
      is_pop = 1'b1;
      sp_step = nxt_word ? SP_STEP_WORD : SP_STEP_BYTE;
    end else if (op_byte0_i == OP0_POP_CTRL && !op_byte1_i[7] && op_byte1_i[3:0] == OP1_POP_CTRL_TAIL) begin
      nxt_class = CLS_POP_CTRL;
      nxt_word = 1'b1;
      nxt_ctrl = ctrl_reg_t'(op_byte1_i[CTRL_LSB +: 3]);
      nxt_illegal = (op_byte1_i[CTRL_LSB +: 3] == CTRL_NONE);
      nxt_len = LEN_TWO;
      nxt_cyc = CYC_THREE;
      is_pop = ~nxt_illegal;
      sp_step = SP_STEP_WORD;
    end else if (op_byte0_i == OP0_POP_MULTI) begin
      nxt_class = CLS_POP_MULTI;
      nxt_word = 1'b1;
      nxt_mask = op_byte1_i;
      nxt_len = LEN_TWO;
      nxt_cyc = (restore_cnt >= MULTI_MIN_COUNT) ? {restore_cnt, 1'b0} : CYC_THREE;
      is_pop = 1'b1;
      // Every restored register is a word
      sp_step = {11'h000, restore_cnt, 1'b0};
    end else begin
      nxt_illegal = 1'b1;
    end
    // Stack pointer only moves for pops; other classes report it unchanged
    nxt_paddr = stack_ptr_i;
    nxt_sp = is_pop ? stack_ptr_i + sp_step : stack_ptr_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      done_ff <= 1'b0;
      class_ff <= CLS_NONE;
      illegal_ff <= 1'b0;
      len_ff <= 3'h0;
      cyc_ff <= 5'h00;
      word_ff <= 1'b0;
      src_ff <= 4'h0;
      dest_ff <= 4'h0;
      bsel_ff <= BYTE_SEL_LOW;
      ssrc_ff <= SSRC_OTHER_BYTE;
      ctrl_ff <= CTRL_NONE;
      mask_ff <= 8'h00;
      paddr_ff <= 16'h0000;
      sp_ff <= 16'h0000;
    end else begin
      done_ff <= nxt_done;
      class_ff <= nxt_class;
      illegal_ff <= nxt_illegal;
      len_ff <= nxt_len;
      cyc_ff <= nxt_cyc;
      word_ff <= nxt_word;
      src_ff <= nxt_src;
      dest_ff <= nxt_dest;
      bsel_ff <= nxt_bsel;
      ssrc_ff <= nxt_ssrc;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      paddr_ff <= nxt_paddr;
      sp_ff <= nxt_sp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dec_done_o = done_ff;
  assign insn_class_o = class_ff;
  assign illegal_o = illegal_ff;
  assign insn_len_o = len_ff;
  assign insn_cycles_o = cyc_ff;
  assign size_word_o = word_ff;
  assign src_code_o = src_ff;
  assign dest_code_o = dest_ff;
  assign byte_sel_o = bsel_ff;
  assign short_src_o = ssrc_ff;
  assign ctrl_sel_o = ctrl_ff;
  assign restore_mask_o = mask_ff;
  assign pop_addr_o = paddr_ff;
  assign new_sp_o = sp_ff;

endmodule

/* or_pop_decoder_sva.sv */
/*
  Checker for or_pop_decoder: lengths, cycles, fields and stack results.
  Assumes one clock and a registered answer one cycle after each request.
*/
module or_pop_decoder_chk
  import or_pop_decode_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic dec_valid_i,
  input wire logic [7:0] op_byte0_i,
  input wire logic [7:0] op_byte1_i,
  input wire logic [15:0] stack_ptr_i,
  input wire logic dec_done_o,
  input wire logic illegal_o,
  input wire logic [2:0] insn_len_o,
  input wire logic [4:0] insn_cycles_o,
  input wire logic byte_sel_o,
  input wire logic [1:0] short_src_o,
  input wire logic [7:0] restore_mask_o,
  input wire logic [15:0] pop_addr_o,
  input wire logic [15:0] new_sp_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////
  wire logic imm_g = dec_valid_i && op_byte0_i[7:1] == OP0_OR_IMM_G && op_byte1_i[7:4] == OP1_OR_IMM_G;
  wire logic imm_s = dec_valid_i && op_byte0_i[7:3] == OP0_OR_IMM_S && op_byte0_i[2:0] > 3'h2;
  wire logic rm_s = dec_valid_i && op_byte0_i[7:3] == OP0_OR_RM_S;
  wire logic pop_g = dec_valid_i && op_byte0_i[7:1] == OP0_POP_G && op_byte1_i[7:4] == OP1_POP_G;
  wire logic control_register_pop = dec_valid_i && op_byte0_i == OP0_POP_CTRL && op_byte1_i[3:0] == OP1_POP_CTRL_TAIL;
  wire logic multi_register_pop = dec_valid_i && op_byte0_i == OP0_POP_MULTI;
  wire logic popw = dec_valid_i && op_byte0_i[7:4] == OP0_POP_W_S && op_byte0_i[2:0] == OP0_POP_S_TAIL;
  chk_imm_word_len:
    assert property (imm_g && op_byte1_i[3:0] < 4'h6 |=> insn_len_o == 3'h3 + {2'h0, $past(op_byte0_i[0])})
    else $error("general OR immediate length wrong");
  chk_simm_reg:
    assert property (imm_s |=> insn_cycles_o == ($past(op_byte0_i[2:0]) < 3'h5 ? 5'h1 : 5'h3))
    else $error("short OR immediate cycles wrong");
  chk_simm_sel:
    assert property (imm_s && op_byte0_i[2:0] < 3'h5 |=> byte_sel_o == !$past(op_byte0_i[2]))
    else $error("short OR immediate byte select wrong");
  chk_ssrc_field:
    assert property (rm_s |=> short_src_o == $past(op_byte0_i[1:0]) && byte_sel_o == $past(op_byte0_i[2]))
    else $error("short OR source fields wrong");
  chk_ssrc_timing:
    assert property (rm_s && op_byte0_i[1:0] == 2'h0 |=> insn_len_o == 3'h1 && insn_cycles_o == 5'h2)
    else $error("short OR register source timing wrong");
  chk_popg_reg:
    assert property (pop_g && op_byte1_i[3:0] < 4'h6 |=> insn_len_o == 3'h2 && insn_cycles_o == 5'h3)
    else $error("general pop register timing wrong");
  chk_control_register_pop_reject:
    assert property (control_register_pop && op_byte1_i[6:4] == 3'h0 |=> dec_done_o && illegal_o && new_sp_o == $past(stack_ptr_i))
    else $error("control pop code zero accepted");
  chk_multi_register_pop_mask:
    assert property (multi_register_pop |=> restore_mask_o == $past(op_byte1_i) && insn_len_o == 3'h2)
    else $error("multi pop mask wrong");
  chk_multi_register_pop_cycles:
    assert property (multi_register_pop && $countones(op_byte1_i) > 1 |=> insn_cycles_o == 5'($countones($past(op_byte1_i)) * 2))
    else $error("multi pop cycles wrong");
  chk_popw_stack:
    assert property (popw |=> pop_addr_o == $past(stack_ptr_i) && new_sp_o == $past(stack_ptr_i) + 16'h2)
    else $error("short word pop stack wrong");
  cov_multi_register_pop: cover property (multi_register_pop ##1 dec_done_o);
  cov_control_register_pop: cover property (control_register_pop ##1 illegal_o);
  cov_imm: cover property (imm_g ##1 dec_done_o);
endmodule
bind or_pop_decoder or_pop_decoder_chk u_chk (.*);

/* fetch_model.sv */
/*
  Fetch side model: offers two opcode bytes and the stack pointer for one cycle.
  Assumes issue is called by the bench; it changes lines at falling edges only.
*/
module fetch_model (
  input wire logic core_clk_i,
  output logic dec_valid_o,
  output logic [7:0] byte0_o,
  output logic [7:0] byte1_o,
  output logic [15:0] sp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dec_valid_o = 1'b0;
    byte0_o = 8'hff;
    byte1_o = 8'hff;
    sp_o = 16'hffff;
  end
  ////////////////////////
  // Released lines carry the inverse so a stale byte never looks current
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] sp);
    @(negedge core_clk_i);
    dec_valid_o = 1'b1;
    byte0_o = b0;
    byte1_o = b1;
    sp_o = sp;
    @(negedge core_clk_i);
    dec_valid_o = 1'b0;
    byte0_o = ~b0;
    byte1_o = ~b1;
    sp_o = ~sp;
  endtask
endmodule

/* logic_or_and_pop_decoder_bench.sv */
/*
  Bench for or_pop_decoder: each instruction form decoded and judged.
  Assumes the fetch model drives the request lines at falling edges.
*/
module logic_or_and_pop_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import or_pop_decode_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic dec_valid_i, dec_done_o, illegal_o, size_word_o, byte_sel_o;
  logic [7:0] op_byte0_i, op_byte1_i, restore_mask_o;
  logic [15:0] stack_ptr_i, pop_addr_o, new_sp_o;
  insn_class_t insn_class_o;
  ctrl_reg_t ctrl_sel_o;
  logic [2:0] insn_len_o;
  logic [4:0] insn_cycles_o;
  logic [3:0] src_code_o, dest_code_o;
  logic [1:0] short_src_o;
  int n_mismatch = 0;
  int check_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  or_pop_decoder DUT (.*);
  fetch_model u_fetch (.core_clk_i(core_clk_i), .dec_valid_o(dec_valid_i), .byte0_o(op_byte0_i),
    .byte1_o(op_byte1_i), .sp_o(stack_ptr_i));
  ////////////////////////
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask
  // Bounded wait for the answer; a missing answer ends the run
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] sp);
    u_fetch.issue(b0, b1, sp);
    for (int i = 0; i < 4 && dec_done_o !== 1'b1; i++) @(negedge core_clk_i);
    if (dec_done_o !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic lc(input logic [2:0] l, input logic [4:0] c);
    check("len", 16'(insn_len_o), 16'(l));
    check("cycles", 16'(insn_cycles_o), 16'(c));
  endtask
  ////////////////////////
  task automatic t_or_imm();
    run(8'h76, 8'h30, 16'h0);
    lc(3'h3, 5'h02);
    run(8'h77, 8'h35, 16'h0);
    lc(3'h4, 5'h02);
    check("class", 16'(insn_class_o), 16'(CLS_OR_IMM_G));
    check("dest", 16'(dest_code_o), 16'h0005);
    // General OR, word, source [A0] to absolute: two memory operands
    run(8'h99, 8'h6f, 16'h0);
    lc(3'h4, 5'h04);
    check("src", 16'(src_code_o), 16'h0006);
    check("dest", 16'(dest_code_o), 16'h000f);
    check("word", 16'(size_word_o), 16'h1);
    run(8'h98, 8'h01, 16'h0);
    lc(3'h2, 5'h02);
    run(8'h9b, 8'h00, 16'h0);
    lc(3'h2, 5'h01);
    check("sel", 16'(byte_sel_o), 16'h1);
    run(8'h9c, 8'h00, 16'h0);
    check("sel", 16'(byte_sel_o), 16'h0);
    run(8'h9e, 8'h00, 16'h0);
    lc(3'h3, 5'h03);
    run(8'h9f, 8'h00, 16'h0);
    lc(3'h4, 5'h03);
  endtask
  task automatic t_or_src();
    logic [7:0] ops [4] = '{8'h18, 8'h1d, 8'h1e, 8'h1b};
    logic [2:0] lens [4] = '{3'h1, 3'h2, 3'h2, 3'h3};
    for (int i = 0; i < 4; i++) begin
      run(ops[i], 8'h00, 16'h0);
      check("src", 16'(short_src_o), 16'(ops[i][1:0]));
      check("sel", 16'(byte_sel_o), 16'(ops[i][2]));
      lc(lens[i], i == 0 ? 5'h02 : 5'h03);
    end
  endtask
  task automatic t_pop();
    run(8'h74, 8'hd0, 16'h0100);
    lc(3'h2, 5'h03);
    check("addr", pop_addr_o, 16'h0100);
    check("sp", new_sp_o, 16'h0101);
    run(8'h75, 8'hd6, 16'h0200);
    lc(3'h2, 5'h04);
    check("sp", new_sp_o, 16'h0202);
    check("word", 16'(size_word_o), 16'h1);
    run(8'h74, 8'hd8, 16'h0);
    lc(3'h3, 5'h04);
    run(8'h75, 8'hdf, 16'hfffe);
    lc(3'h4, 5'h04);
    check("sp", new_sp_o, 16'h0000);
    run(8'h9a, 8'h00, 16'h0010);
    check("sp", new_sp_o, 16'h0011);
    run(8'hda, 8'h00, 16'h0010);
    check("sp", new_sp_o, 16'h0012);
  endtask
  task automatic t_control_register_pop();
    for (int c = 0; c < 8; c++) begin
      run(8'heb, {1'b0, 3'(c), 4'h3}, 16'h0300);
      check("illegal", 16'(illegal_o), 16'(c == 0));
      check("ctrl", 16'(ctrl_sel_o), 16'(c));
      check("sp", new_sp_o, (c == 0) ? 16'h0300 : 16'h0302);
    end
  endtask
  task automatic t_multi_register_pop();
    logic [7:0] masks [4] = '{8'h03, 8'h80, 8'hff, 8'ha0};
    logic [4:0] cyc [4] = '{5'h04, 5'h03, 5'h10, 5'h04};
    logic [15:0] sps [4] = '{16'h0404, 16'h0402, 16'h0410, 16'h0404};
    for (int i = 0; i < 4; i++) begin
      run(8'hed, masks[i], 16'h0400);
      lc(3'h2, cyc[i]);
      check("mask", 16'(restore_mask_o), 16'(masks[i]));
      check("sp", new_sp_o, sps[i]);
    end
  endtask
  initial begin
    repeat (8) @(negedge core_clk_i);
    check("done", 16'(dec_done_o), 16'h0);
    rstn_i = 1'b1;
    t_or_imm();
    t_or_src();
    t_pop();
    t_control_register_pop();
    t_multi_register_pop();
    run(8'h00, 8'h00, 16'h0);
    check("illegal", 16'(illegal_o), 16'h1);
    stop_test();
  end
endmodule
